/* File: hw/agofc_top.sv */
// Gain, clock/reference mode and serial output format control with LVDS serializer
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module agofc_top
	import agofc_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic [11:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [11:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic LINK_CLK,
	input wire logic REFERENCE_SOURCE_PIN,
	input wire logic [agofc_pkg::NUM_CH*agofc_pkg::SAMPLE_W-1:0] SAMPLE_DATA,
	input wire logic SAMPLE_VALID,
	output logic SAMPLE_READY,
	output logic [agofc_pkg::NUM_CH*agofc_pkg::GAIN_W-1:0] CHANNEL_GAIN_CODE,
	output logic DIFFERENTIAL_CLOCK_SELECT,
	output logic DUTY_CORRECTION_ENABLE,
	output logic EXTERNAL_REFERENCE_ACTIVE,
	output logic COMMON_MODE_PIN_INPUT,
	output logic [agofc_pkg::NUM_CH-1:0] SERIAL_DATA,
	output logic SERIAL_BIT_CLOCK,
	output logic FRAME_CLOCK_OUTPUT
);
	localparam int BW = $clog2(SAMPLE_W);
	localparam logic [BW-1:0] LAST_BIT = BW'(SAMPLE_W - 1);
	localparam logic [BW-1:0] MID_BIT = BW'(HALF_BITS);
	// Slot length is measured up to 16 system clocks; longer slots just centre less exactly
	localparam int SLOT_W = 4;

	logic [15:0] gain_lo;
	logic [15:0] gain_hi;
	logic [15:0] clk_ref;
	logic [15:0] fmt;
	logic aw_held;
	logic w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic ref_s1;
	logic ref_s2;
	logic lk_s1;
	logic lk_s2;
	logic lk_d;
	logic bit_tick;
	logic [BW-1:0] bit_idx;
	logic [NUM_CH*SAMPLE_W-1:0] word;
	logic word_loaded;
	logic fifo_valid;
	logic [NUM_CH*SAMPLE_W-1:0] fifo_data;
	logic take_word;
	logic underrun;
	logic [1:0] phase;
	logic sdr;
	logic fall_sel;
	logic [SLOT_W-1:0] slot_cnt;
	logic [SLOT_W-1:0] half_slot;
	logic mid_tick;

	// Gain codes above twelve are not legal; clamp so the datapath never sees them
	function automatic logic [GAIN_W-1:0] clamp_gain(input logic [GAIN_W-1:0] code);
		clamp_gain = (code > GAIN_MAX) ? GAIN_MAX : code;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// AXI4-Lite write path: address and data accepted independently
	assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
	assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (aw_held && w_held) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= (aw_addr[11:10] == 2'b00 &&
					(aw_addr[9:0] == ADDR_GAIN_LO || aw_addr[9:0] == ADDR_GAIN_HI ||
					aw_addr[9:0] == ADDR_CLK_REF || aw_addr[9:0] == ADDR_FORMAT ||
					aw_addr[9:0] == ADDR_STATUS)) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	logic wr_go;
	assign wr_go = aw_held && w_held && aw_addr[11:10] == 2'b00;

	// Configuration registers; fixed-one bits are forced so a careless write cannot clear them
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			gain_lo <= GAIN_RESET;
			gain_hi <= GAIN_RESET;
			clk_ref <= CLK_REF_RESET;
			fmt <= FORMAT_RESET;
		end else if (wr_go) begin
			if (aw_addr[9:0] == ADDR_GAIN_LO) begin
				gain_lo <= merge16(gain_lo, w_data, w_strb);
			end
			if (aw_addr[9:0] == ADDR_GAIN_HI) begin
				gain_hi <= merge16(gain_hi, w_data, w_strb);
			end
			if (aw_addr[9:0] == ADDR_CLK_REF) begin
				clk_ref <= merge16(clk_ref, w_data, w_strb) | CLK_REF_RESET;
			end
			if (aw_addr[9:0] == ADDR_FORMAT) begin
				fmt <= merge16(fmt, w_data, w_strb) | FORMAT_RESET;
			end
		end
	end

	// AXI4-Lite read path
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= RESP_OKAY;
			S_AXI_RDATA <= '0;
			if (S_AXI_ARADDR[11:10] != 2'b00) begin
				S_AXI_RRESP <= RESP_SLVERR;
			end else if (S_AXI_ARADDR[9:0] == ADDR_GAIN_LO) begin
				S_AXI_RDATA <= {16'h0000, gain_lo};
			end else if (S_AXI_ARADDR[9:0] == ADDR_GAIN_HI) begin
				S_AXI_RDATA <= {16'h0000, gain_hi};
			end else if (S_AXI_ARADDR[9:0] == ADDR_CLK_REF) begin
				S_AXI_RDATA <= {16'h0000, clk_ref};
			end else if (S_AXI_ARADDR[9:0] == ADDR_FORMAT) begin
				S_AXI_RDATA <= {16'h0000, fmt};
			end else if (S_AXI_ARADDR[9:0] == ADDR_STATUS) begin
				S_AXI_RDATA <= {28'h000_0000, underrun, EXTERNAL_REFERENCE_ACTIVE,
					COMMON_MODE_PIN_INPUT, word_loaded};
			end else begin
				S_AXI_RRESP <= RESP_SLVERR;
			end
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// Gain outputs: ch1-4 lowest nibble first, ch5-8 highest channel in lowest nibble
	genvar g;
	generate
		for (g = 0; g < NUM_CH / 2; g++) begin : g_gain
			always_ff @(posedge CLK_SYS or negedge RST_N) begin
				if (!RST_N) begin
					CHANNEL_GAIN_CODE[g*GAIN_W +: GAIN_W] <= '0;
					CHANNEL_GAIN_CODE[(NUM_CH-1-g)*GAIN_W +: GAIN_W] <= '0;
				end else begin
					CHANNEL_GAIN_CODE[g*GAIN_W +: GAIN_W] <=
						clamp_gain(gain_lo[g*GAIN_W +: GAIN_W]);
					CHANNEL_GAIN_CODE[(NUM_CH-1-g)*GAIN_W +: GAIN_W] <=
						clamp_gain(gain_hi[g*GAIN_W +: GAIN_W]);
				end
			end
		end
	endgenerate

	// Mode outputs; reference pin is asynchronous so it is synchronised first
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ref_s1 <= 1'b1;
			ref_s2 <= 1'b1;
			DIFFERENTIAL_CLOCK_SELECT <= 1'b0;
			DUTY_CORRECTION_ENABLE <= 1'b0;
			EXTERNAL_REFERENCE_ACTIVE <= 1'b0;
			COMMON_MODE_PIN_INPUT <= 1'b0;
		end else begin
			ref_s1 <= REFERENCE_SOURCE_PIN;
			ref_s2 <= ref_s1;
			DIFFERENTIAL_CLOCK_SELECT <= clk_ref[B_DIFFERENTIAL_CLOCK_SELECT];
			DUTY_CORRECTION_ENABLE <= clk_ref[B_DCC];
			EXTERNAL_REFERENCE_ACTIVE <= !ref_s2;
			COMMON_MODE_PIN_INPUT <= !ref_s2 && clk_ref[B_CM_REF];
		end
	end

	assign phase = clk_ref[B_PHASE_LO +: 2];
	assign sdr = fmt[B_SDR];
	assign fall_sel = sdr && fmt[B_FALL];

	// Twelve-times bit rate comes from the link clock; each of its edges is one bit slot
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			lk_s1 <= 1'b0;
			lk_s2 <= 1'b0;
			lk_d <= 1'b0;
		end else begin
			lk_s1 <= LINK_CLK;
			lk_s2 <= lk_s1;
			lk_d <= lk_s2;
		end
	end
	assign bit_tick = lk_s2 ^ lk_d;

	// Slot length measured in system clocks so bit clock edges land mid-window
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			slot_cnt <= '1;
			half_slot <= '0;
		end else if (bit_tick) begin
			slot_cnt <= '0;
			half_slot <= {1'b0, slot_cnt[SLOT_W-1:1]} + SLOT_W'(1);
		end else if (slot_cnt != '1) begin
			slot_cnt <= slot_cnt + 1'b1;
		end
	end
	assign mid_tick = !bit_tick && slot_cnt == half_slot;

	// A new word is taken at the last bit slot; an empty FIFO repeats nothing and flags underrun
	assign take_word = bit_tick && bit_idx == LAST_BIT;
	agofc_fifo #(
		.WIDTH(NUM_CH*SAMPLE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.in_valid(SAMPLE_VALID),
		.in_ready(SAMPLE_READY),
		.in_data(SAMPLE_DATA),
		.out_valid(fifo_valid),
		.out_ready(take_word),
		.out_data(fifo_data)
	);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			bit_idx <= LAST_BIT;
			word <= '0;
			word_loaded <= 1'b0;
			underrun <= 1'b0;
		end else if (bit_tick) begin
			if (bit_idx == LAST_BIT) begin
				bit_idx <= '0;
				word <= fifo_valid ? fifo_data : '0;
				word_loaded <= fifo_valid;
				underrun <= underrun || !fifo_valid;
			end else begin
				bit_idx <= bit_idx + 1'b1;
			end
		end
	end

	// Per-lane serialiser: format conversion then bit selection
	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++) begin : g_lane
			logic [SAMPLE_W-1:0] lane_word;
			logic [BW-1:0] pick;
			assign lane_word = word[c*SAMPLE_W +: SAMPLE_W] ^
				{fmt[B_TWOS], {(SAMPLE_W-1){1'b0}}};
			assign pick = fmt[B_MSB_FIRST] ? LAST_BIT - bit_idx : bit_idx;
			always_ff @(posedge CLK_SYS or negedge RST_N) begin
				if (!RST_N) begin
					SERIAL_DATA[c] <= 1'b0;
				end else begin
					SERIAL_DATA[c] <= lane_word[pick];
				end
			end
		end
	endgenerate

	// Frame clock from the bit index, bit clock from mid-slot ticks except in the edge-aligned DDR phases; both follow bit_tick, so they stay in lockstep
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			SERIAL_BIT_CLOCK <= 1'b0;
			FRAME_CLOCK_OUTPUT <= 1'b0;
		end else begin
			FRAME_CLOCK_OUTPUT <= bit_idx < MID_BIT;
			if (sdr) begin
				// One pulse per bit at mid-slot; edge select picks the capturing edge
				SERIAL_BIT_CLOCK <= mid_tick ? !fall_sel : fall_sel;
			end else begin
				// One edge per bit; level set, not toggled, so a missed slot self-heals
				unique case (phase)
					2'b00: begin
						if (mid_tick) begin
							SERIAL_BIT_CLOCK <= bit_idx[0];
						end
					end
					2'b01: begin
						if (mid_tick) begin
							SERIAL_BIT_CLOCK <= !bit_idx[0];
						end
					end
					// Edges on the data transitions, a quarter clock away from centre
					2'b10: SERIAL_BIT_CLOCK <= bit_idx[0];
					2'b11: SERIAL_BIT_CLOCK <= !bit_idx[0];
				endcase
			end
		end
	end
endmodule // agofc_top

// Small flip-flop FIFO with valid/ready on both sides
module agofc_fifo #(
	parameter int WIDTH = 96,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule // agofc_fifo

/* File: hw/agofc_pkg.sv */
// Package for the converter gain and output format control block
package agofc_pkg;
	localparam int NUM_CH = 8;
	localparam int SAMPLE_W = 12;
	localparam int GAIN_W = 4;
	localparam int FIFO_DEPTH = 4;
	localparam int HALF_BITS = 6;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_GAIN_LO = 8'h2a;
	localparam logic [7:0] IDX_GAIN_HI = 8'h2b;
	localparam logic [7:0] IDX_CLK_REF = 8'h42;
	localparam logic [7:0] IDX_FORMAT = 8'h46;
	localparam logic [7:0] IDX_STATUS = 8'h50;
	localparam logic [9:0] ADDR_GAIN_LO = {IDX_GAIN_LO, 2'b00};
	localparam logic [9:0] ADDR_GAIN_HI = {IDX_GAIN_HI, 2'b00};
	localparam logic [9:0] ADDR_CLK_REF = {IDX_CLK_REF, 2'b00};
	localparam logic [9:0] ADDR_FORMAT = {IDX_FORMAT, 2'b00};
	localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
	// Field positions, clock/reference register
	localparam int B_DIFFERENTIAL_CLOCK_SELECT = 0;
	localparam int B_DCC = 2;
	localparam int B_CM_REF = 3;
	localparam int B_PHASE_LO = 5;
	localparam int B_FIXED_HI = 15;
	// Field positions, format register
	localparam int B_TWOS = 2;
	localparam int B_MSB_FIRST = 3;
	localparam int B_SDR = 4;
	localparam int B_FALL = 13;
	localparam int B_FIXED_MID = 9;
	localparam logic [15:0] CLK_REF_RESET = 16'h8000;
	localparam logic [15:0] FORMAT_RESET = 16'h8200;
	localparam logic [15:0] GAIN_RESET = 16'h0000;
	localparam logic [3:0] GAIN_MAX = 4'hc;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hw/agofc_fifo.sv */
// Intentionally empty: the sample FIFO sits beside the block that uses it, with all other logic

/* File: tb/agofc_sva.sv */
// Port checker for the gain and output format block
`timescale 1ns/1ps
module agofc_sva (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic REFERENCE_SOURCE_PIN,
	input wire logic [31:0] CHANNEL_GAIN_CODE,
	input wire logic EXTERNAL_REFERENCE_ACTIVE,
	input wire logic COMMON_MODE_PIN_INPUT,
	input wire logic [7:0] SERIAL_DATA,
	input wire logic SERIAL_BIT_CLOCK,
	input wire logic FRAME_CLOCK_OUTPUT
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	sequence s_pin_low;
		!REFERENCE_SOURCE_PIN [*4];
	endsequence
	sequence s_frame_hi;
		FRAME_CLOCK_OUTPUT [*8];
	endsequence
	property p_gain_max;
		CHANNEL_GAIN_CODE[3:0] <= 4'hc;
	endproperty
	a_gain_max: assert property (p_gain_max) else $error("gain code above twelve");
	property p_ext_ref;
		s_pin_low |-> EXTERNAL_REFERENCE_ACTIVE;
	endproperty
	a_ext_ref: assert property (p_ext_ref) else $error("external reference not active");
	property p_cm_in;
		$rose(COMMON_MODE_PIN_INPUT) |-> ##[0:3] EXTERNAL_REFERENCE_ACTIVE;
	endproperty
	a_cm_in: assert property (p_cm_in) else $error("common mode input without ext ref");
	property p_frame_hi;
		$rose(FRAME_CLOCK_OUTPUT) |-> s_frame_hi;
	endproperty
	a_frame_hi: assert property (p_frame_hi) else $error("frame high too short");
	property p_frame_lo;
		$fell(FRAME_CLOCK_OUTPUT) |-> !FRAME_CLOCK_OUTPUT [*8];
	endproperty
	a_frame_lo: assert property (p_frame_lo) else $error("frame low too short");
	// Holds for the centred DDR phases and SDR; the edge-aligned phases are never run
	property p_centre;
		$changed(SERIAL_BIT_CLOCK) |-> $stable(SERIAL_DATA);
	endproperty
	a_centre: assert property (p_centre) else $error("bit clock edge on data change");
	property p_wr_ans;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> ##1 S_AXI_BVALID;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write response late");
	property p_b_block;
		S_AXI_BVALID |-> !S_AXI_AWREADY;
	endproperty
	a_b_block: assert property (p_b_block) else $error("write address taken during response");
	property p_rd_ans;
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read response late");
	property p_r_block;
		S_AXI_RVALID |-> !S_AXI_ARREADY;
	endproperty
	a_r_block: assert property (p_r_block) else $error("read address taken during response");
endmodule // agofc_sva
bind agofc_top agofc_sva u_sva (.*);

/* File: tb/agofc_rx_model.sv */
// Receiver model capturing lane 0 of the serial output
`timescale 1ns/1ps
module agofc_rx_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bclk,
	input wire logic frame,
	input wire logic lane,
	input wire logic sdr,
	input wire logic fall,
	output logic [11:0] word,
	output logic [7:0] cnt
);
	logic pb;
	logic pf;
	logic [3:0] n;
	logic [10:0] sh;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pb <= 1'h0;
			pf <= 1'h0;
			n <= 4'hc;
			sh <= 11'h000;
			word <= 12'h000;
			cnt <= 8'h00;
		end else begin
			pb <= bclk;
			pf <= frame;
			if (frame && !pf) n <= 4'h0;
			else if (bclk != pb && (!sdr || bclk != fall) && n < 4'hc) begin
				n <= n + 4'h1;
				if (n < 4'hb) sh[n] <= lane;
				if (n == 4'hb) begin
					word <= {lane, sh};
					cnt <= cnt + 8'h01;
				end
			end
		end
	end
endmodule // agofc_rx_model

/* File: tb/tb_top.sv */
// Self-checking bench for the gain and output format block
`timescale 1ns/1ps
module tb_top;
	import agofc_pkg::*;
	logic CLK_SYS = 0, RST_N = 0, LINK_CLK = 0, link_en = 0;
	logic [11:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
	logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_ARVALID = 0;
	logic S_AXI_BREADY = 1, S_AXI_RREADY = 1, REFERENCE_SOURCE_PIN = 1, SAMPLE_VALID = 0;
	logic [31:0] S_AXI_WDATA = 0;
	logic rx_sdr = 0, rx_fall = 0;
	logic [3:0] S_AXI_WSTRB = 4'hf;
	logic [95:0] SAMPLE_DATA = 0;
	wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
	wire [31:0] S_AXI_RDATA, CHANNEL_GAIN_CODE;
	wire SAMPLE_READY, DIFFERENTIAL_CLOCK_SELECT, DUTY_CORRECTION_ENABLE;
	wire EXTERNAL_REFERENCE_ACTIVE, COMMON_MODE_PIN_INPUT, SERIAL_BIT_CLOCK, FRAME_CLOCK_OUTPUT;
	wire [7:0] SERIAL_DATA, rx_cnt;
	wire [11:0] rx_word;
	int errors = 0, n_tests = 0, cyc = 0;
	always #12.5 CLK_SYS = ~CLK_SYS;
	// Link clock only runs while a stream test wants it
	always #100 if (link_en) LINK_CLK = ~LINK_CLK;
	agofc_top dut (.*);
	agofc_rx_model rx (.clk(CLK_SYS), .rst_n(RST_N), .bclk(SERIAL_BIT_CLOCK),
		.frame(FRAME_CLOCK_OUTPUT), .lane(SERIAL_DATA[0]), .sdr(rx_sdr), .fall(rx_fall),
		.word(rx_word), .cnt(rx_cnt));
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_t, w_t, b_t;
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		do begin
			@(negedge CLK_SYS);
			aw_t = S_AXI_AWVALID && S_AXI_AWREADY;
			w_t = S_AXI_WVALID && S_AXI_WREADY;
			b_t = S_AXI_BVALID;
			if (b_t) chk("bresp", er, S_AXI_BRESP);
			@(posedge CLK_SYS);
			if (aw_t) S_AXI_AWVALID <= 1'h0;
			if (w_t) S_AXI_WVALID <= 1'h0;
		end while (!b_t);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		do @(negedge CLK_SYS); while (!S_AXI_ARREADY);
		@(posedge CLK_SYS);
		S_AXI_ARVALID <= 1'h0;
		do @(negedge CLK_SYS); while (!S_AXI_RVALID);
		chk("rdata", e, S_AXI_RDATA);
		chk("rresp", er, S_AXI_RRESP);
		@(posedge CLK_SYS);
	endtask
	task automatic wait_words(input int k);
		logic [7:0] c;
		repeat (k) begin
			c = rx_cnt;
			while (rx_cnt == c) @(posedge CLK_SYS);
		end
	endtask
	task automatic t_defaults();
		rd(ADDR_CLK_REF, 32'h0000_8000, RESP_OKAY);
		rd(ADDR_FORMAT, 32'h0000_8200, RESP_OKAY);
		chk("diff clock", 0, DIFFERENTIAL_CLOCK_SELECT);
		rd(12'h200, 32'h0000_0000, RESP_SLVERR);
		wr(12'h200, 32'h0000_ffff, RESP_SLVERR);
	endtask
	task automatic t_clkref();
		wr(ADDR_CLK_REF, 32'h0000_800d, RESP_OKAY);
		rd(ADDR_CLK_REF, 32'h0000_800d, RESP_OKAY);
		@(posedge CLK_SYS);
		chk("diff clock", 1, DIFFERENTIAL_CLOCK_SELECT);
		chk("duty corr", 1, DUTY_CORRECTION_ENABLE);
		chk("cm input", 0, COMMON_MODE_PIN_INPUT);
		REFERENCE_SOURCE_PIN <= 1'h0;
		repeat (5) @(posedge CLK_SYS);
		chk("ext ref", 1, EXTERNAL_REFERENCE_ACTIVE);
		chk("cm input", 1, COMMON_MODE_PIN_INPUT);
		REFERENCE_SOURCE_PIN <= 1'h1;
		repeat (5) @(posedge CLK_SYS);
		chk("ext ref", 0, EXTERNAL_REFERENCE_ACTIVE);
	endtask
	task automatic t_gain();
		wr(ADDR_GAIN_LO, 32'h0000_3c0d, RESP_OKAY);
		wr(ADDR_GAIN_HI, 32'h0000_1234, RESP_OKAY);
		repeat (2) @(posedge CLK_SYS);
		chk("gain codes", 32'h4321_3c0c, CHANNEL_GAIN_CODE);
	endtask
	task automatic t_stream(input logic [15:0] cr, input logic [15:0] fmt, input logic [11:0] e);
		int n;
		wr(ADDR_CLK_REF, {16'h0000, cr}, RESP_OKAY);
		wr(ADDR_FORMAT, {16'h0000, fmt}, RESP_OKAY);
		rx_sdr <= fmt[B_SDR];
		rx_fall <= fmt[B_FALL];
		SAMPLE_DATA <= {84'h0, 12'h5a3};
		SAMPLE_VALID <= 1'h1;
		n = 0;
		repeat (8) begin
			@(negedge CLK_SYS);
			if (SAMPLE_READY) n++;
			@(posedge CLK_SYS);
		end
		SAMPLE_VALID <= 1'h0;
		chk("fifo fill", 1, n == 4 || n == 5);
		link_en <= 1'h1;
		for (int i = 0; i < 8 && rx_word !== e; i++) wait_words(1);
		chk("lane word", e, rx_word);
		wait_words(8);
		link_en <= 1'h0;
		rd(ADDR_STATUS, 32'h0000_0008, RESP_OKAY);
	endtask
	task automatic report_and_stop();
		if (errors == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge CLK_SYS) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (12) @(posedge CLK_SYS);
		RST_N <= 1'h1;
		@(posedge CLK_SYS);
		t_defaults();
		t_clkref();
		t_gain();
		t_stream(16'h800d, 16'h8200, 12'h5a3);
		t_stream(16'h802d, 16'h8208, 12'hc5a);
		t_stream(16'h800d, 16'h8204, 12'hda3);
		// Single rate only at the bench's slow word rate, far below the limit
		t_stream(16'h800d, 16'h8214, 12'hda3);
		t_stream(16'h800d, 16'ha214, 12'hda3);
		report_and_stop();
	end
endmodule // tb_top
